// File: core/srm_regs.svh
// Register offsets, field positions, reset values and timing figures of the receive status monitor.
// Assumes a 250 MHz pclk and an APB byte address of eight bits.
`ifndef SRM_REGS_SVH
`define SRM_REGS_SVH
// Register byte offsets and the ancillary block selects on paddr[7:6].
`define SRM_ANC_POS 8'h00
`define SRM_STATUS 8'h04
`define SRM_FMT 8'h08
`define SRM_CRC_ERR 8'h0c
`define SRM_FRAME_REF 8'h10
`define SRM_FRAME_CYC 8'h14
`define SRM_HD_ANC_BLK 2'h1
`define SRM_CP_ANC_BLK 2'h2
// Reset values.
`define SRM_ANC_LINE_RST 11'h008
`define SRM_ANC_HPOS_RST 12'h000
`define SRM_FRAME_REF_RST 32'h0000_0000
// Timing figures, in ns, and the clock rate in MHz.
`define SRM_CLK_MHZ 250
`define SRM_STUCK_NS 10000
`define SRM_LOCK_LOSS_NS 100000
// Sync preambles and flag bits of the code words.
`define SRM_TRS_P0 10'h3ff
`define SRM_TRS_P1 10'h000
`define SRM_TRS_P2 10'h000
`define SRM_CP_P0 10'h2aa
`define SRM_CP_P1 10'h155
`define SRM_CP_P2 10'h2aa
`define SRM_XYZ_F 8
`define SRM_XYZ_V 7
`define SRM_XYZ_H 6
`define SRM_CP_FRAME 9
`define SRM_CP_ANC 8
// Checksum, ancillary and counter figures.
`define SRM_CRC_POLY 18'h00031
`define SRM_LN_WORDS 2'h2
`define SRM_ANC_WORDS 5'h10
`define SRM_FRAC_SHIFT 11
`define SRM_ERR_MAX 16'hffff
`endif

// File: core/srm_pkg.sv
// Types shared by the receive status monitor modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package srm_pkg;
    // One received ten-bit word with its valid strobe.
    typedef struct packed {
        logic valid;
        logic [9:0] word;
    } srm_rx_t;
    // A sync hit and the code word that followed the preamble.
    typedef struct packed {
        logic hit;
        logic [9:0] code;
    } srm_hit_t;
    // Checksum capture sequence, one-hot.
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_SKIP = 4'h2,
        S_CRC0 = 4'h4,
        S_CRC1 = 4'h8
    } srm_crc_st_t;
endpackage
`default_nettype wire

// File: core/srm_code_search.sv
// Sync code searcher: flags the word that follows a three-word preamble.
// Assumes word-aligned input, one word per valid strobe.
`default_nettype none
module srm_code_search import srm_pkg::*; #(
    parameter logic [9:0] P0 = 10'h000,
    parameter logic [9:0] P1 = 10'h000,
    parameter logic [9:0] P2 = 10'h000
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Word stream in, hit out (same cycle as the code word).
    input wire srm_rx_t rx,
    output srm_hit_t found
);
    logic [9:0] h0_reg, h1_reg, h2_reg; // Last three words, oldest in h2.

    // ---------------------------------------------------------------
    // History shift
    // ---------------------------------------------------------------
    // Shift only on valid words so gaps in the stream do not break a match.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            h0_reg <= 10'h000;
            h1_reg <= 10'h000;
            h2_reg <= 10'h000;
        end
        else if (rx.valid)
        begin
            h0_reg <= rx.word;
            h1_reg <= h0_reg;
            h2_reg <= h1_reg;
        end
    end

    // A hit marks the code word itself, so the caller sees its flag bits directly.
    assign found = '{hit: rx.valid && h2_reg == P0 && h1_reg == P1 && h0_reg == P2, code: rx.word};
endmodule
`default_nettype wire

// File: core/srm_crc18.sv
// Checksum engine: x^18 + x^5 + x^4 + 1 over ten-bit words, LSB first.
// Assumes the caller gates the enable and pulses the clear between lines or packets.
`include "srm_regs.svh"
`default_nettype none
module srm_crc18 (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Control and data.
    input wire logic en,
    input wire logic clr,
    input wire logic [9:0] data,
    // Running checksum.
    output logic [17:0] crc
);
    // One word step; the loop unrolls to plain xor trees.
    function automatic logic [17:0] crc_step(input logic [17:0] c, input logic [9:0] d);
        logic [17:0] r;
        logic fb;
        r = c;
        fb = 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            fb = r[17] ^ d[i];
            r = {r[16:0], 1'b0} ^ (fb ? `SRM_CRC_POLY : 18'h00000);
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // Accumulator
    // ---------------------------------------------------------------
    // Clear wins over a word in the same cycle; the caller never asks for both.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            crc <= 18'h00000;
        else if (clr)
            crc <= 18'h00000;
        else if (en)
            crc <= crc_step(crc, data);
    end
endmodule
`default_nettype wire

// File: core/srm_rx_status_monitor.sv
// Receive status monitor: signal presence, sync search, format detection,
// checksum error counting and ancillary word capture, behind an APB slave.
// Assumes a word-aligned, descrambled ten-bit luma stream synchronous to pclk.
//
// Chosen here: the register offsets and the APB slave port.
`include "srm_regs.svh"
`default_nettype none
module srm_rx_status_monitor import srm_pkg::*; #(
    parameter int LOCK_LOSS_CYC = (`SRM_LOCK_LOSS_NS * `SRM_CLK_MHZ) / 1000
) (
    // Clock and global reset (active low, asynchronous).
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive data path.
    input wire srm_rx_t rx,
    input wire logic cdr_lock,
    input wire logic decoder_active,
    // External equalizer detect pins.
    input wire logic ext_eq_detect_a,
    input wire logic ext_eq_detect_b,
    // Signal presence.
    output logic signal_present
);
    localparam int STUCK_CYC = (`SRM_STUCK_NS * `SRM_CLK_MHZ) / 1000;

    srm_hit_t trs_hit, cp_hit; // Sync hits from the two searchers.
    logic hd_lock_reg, cp_lock_reg; // Searcher lock flags.
    logic [16:0] hd_idle_reg, cp_idle_reg; // Cycles since last hit.
    logic [9:0] prev_word_reg; // Last word, for transition check.
    logic [11:0] stuck_cnt_reg; // Cycles without a transition.
    logic stuck_reg; // Input stuck at one level.
    srm_crc_st_t st_reg; // Checksum capture state.
    logic [1:0] skip_reg; // Line number words left to skip.
    logic [8:0] crc_lo_reg; // First received checksum word.
    logic [17:0] crc_calc; // Recomputed checksum.
    logic crc_clr; // End of a checked line or packet.
    logic crc_bad_reg; // Mismatch pulse.
    logic [15:0] crc_err_reg; // Saturating error count.
    logic [15:0] pix_cnt_reg, ppl_reg; // Words since EAV, words per line.
    logic [15:0] line_cnt_reg, lpf_reg; // Lines since frame start, lines per frame.
    logic prev_v_reg, il_seen_reg, interlaced_reg, frac_reg; // Scan and rate state.
    logic [31:0] fcyc_cnt_reg, fcyc_reg, fref_reg; // Frame period and reference.
    logic [10:0] anc_line_reg; // HD ancillary line.
    logic [11:0] anc_hpos_reg; // HD ancillary position.
    logic [9:0] hd_shadow[16], hd_anc[16], cp_shadow[16], cp_anc[16]; // Ancillary sets.
    logic cp_arm_reg; // Next packet gap carries ancillary words.
    logic [4:0] cp_left_reg; // Compressed ancillary words still to take.
    logic access, wr_do, rd_ok; // APB decode.
    logic [31:0] rd_data; // Read mux.

    wire comp_mode = cp_lock_reg && !hd_lock_reg; // Priority to standard sync.
    wire eav = trs_hit.hit && trs_hit.code[`SRM_XYZ_H];
    wire sync_end = comp_mode ? cp_hit.hit : eav;
    wire hd_fs = eav && !comp_mode && trs_hit.code[`SRM_XYZ_V] && !trs_hit.code[`SRM_XYZ_F] && !prev_v_reg;
    wire cp_fs = cp_hit.hit && comp_mode && cp_hit.code[`SRM_CP_FRAME];
    wire frame_start = hd_fs || cp_fs;

    // ---------------------------------------------------------------
    // Word aligners
    // ---------------------------------------------------------------
    // Both searchers run at once; the lock flags choose the mode.
    srm_code_search #(.P0(`SRM_TRS_P0), .P1(`SRM_TRS_P1), .P2(`SRM_TRS_P2)) u_trs_search (
        .pclk(pclk),
        .presetn(presetn),
        .rx(rx),
        .found(trs_hit)
    );
    srm_code_search #(.P0(`SRM_CP_P0), .P1(`SRM_CP_P1), .P2(`SRM_CP_P2)) u_cp_search (
        .pclk(pclk),
        .presetn(presetn),
        .rx(rx),
        .found(cp_hit)
    );

    // Lock holds until no hit for the loss time; long lines stay well inside it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hd_lock_reg <= 1'b0;
            hd_idle_reg <= 17'h00000;
            cp_lock_reg <= 1'b0;
            cp_idle_reg <= 17'h00000;
        end
        else
        begin
            if (trs_hit.hit)
            begin
                hd_lock_reg <= 1'b1;
                hd_idle_reg <= 17'h00000;
            end
            else if (hd_lock_reg)
            begin
                hd_lock_reg <= hd_idle_reg != 17'(LOCK_LOSS_CYC - 1);
                hd_idle_reg <= hd_idle_reg + 17'h00001;
            end
            if (cp_hit.hit)
            begin
                cp_lock_reg <= 1'b1;
                cp_idle_reg <= 17'h00000;
            end
            else if (cp_lock_reg)
            begin
                cp_lock_reg <= cp_idle_reg != 17'(LOCK_LOSS_CYC - 1);
                cp_idle_reg <= cp_idle_reg + 17'h00001;
            end
        end
    end

    // ---------------------------------------------------------------
    // Signal presence
    // ---------------------------------------------------------------
    // A word that never changes means the line is stuck or absent.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_word_reg <= 10'h000;
            stuck_cnt_reg <= 12'h000;
            stuck_reg <= 1'b0;
            signal_present <= 1'b0;
        end
        else
        begin
            if (rx.valid)
                prev_word_reg <= rx.word;
            if (rx.valid && rx.word != prev_word_reg)
            begin
                stuck_cnt_reg <= 12'h000;
                stuck_reg <= 1'b0;
            end
            else if (stuck_cnt_reg == 12'(STUCK_CYC - 1))
                stuck_reg <= 1'b1;
            else
                stuck_cnt_reg <= stuck_cnt_reg + 12'h001;
            signal_present <= cdr_lock && decoder_active && !stuck_reg;
        end
    end

    // ---------------------------------------------------------------
    // Checksum capture and compare
    // ---------------------------------------------------------------
    // HD skips the two line number words after EAV; compressed packets carry none.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg <= S_IDLE;
            skip_reg <= 2'h0;
            crc_lo_reg <= 9'h000;
            crc_bad_reg <= 1'b0;
        end
        else
        begin
            crc_bad_reg <= 1'b0;
            unique case (st_reg)
                S_IDLE:
                    if (sync_end)
                    begin
                        st_reg <= comp_mode ? S_CRC0 : S_SKIP;
                        skip_reg <= `SRM_LN_WORDS;
                    end
                S_SKIP:
                    if (rx.valid)
                    begin
                        skip_reg <= skip_reg - 2'h1;
                        if (skip_reg == 2'h1)
                            st_reg <= S_CRC0;
                    end
                S_CRC0:
                    if (rx.valid)
                    begin
                        crc_lo_reg <= rx.word[8:0];
                        st_reg <= S_CRC1;
                    end
                S_CRC1:
                    if (rx.valid)
                    begin
                        crc_bad_reg <= {rx.word[8:0], crc_lo_reg} != crc_calc;
                        st_reg <= S_IDLE;
                    end
            endcase
        end
    end

    assign crc_clr = st_reg == S_CRC1 && rx.valid;

    // The received checksum words are kept out of the running sum.
    srm_crc18 u_crc (
        .pclk(pclk),
        .presetn(presetn),
        .en(rx.valid && (st_reg == S_IDLE || st_reg == S_SKIP)),
        .clr(crc_clr),
        .data(rx.word),
        .crc(crc_calc)
    );

    // A mismatch in the cycle of a software clear still counts, so none is lost.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            crc_err_reg <= 16'h0000;
        else if (crc_bad_reg)
        begin
            if (wr_do && paddr == `SRM_CRC_ERR)
                crc_err_reg <= 16'h0001;
            else if (crc_err_reg != `SRM_ERR_MAX)
                crc_err_reg <= crc_err_reg + 16'h0001;
        end
        else if (wr_do && paddr == `SRM_CRC_ERR)
            crc_err_reg <= 16'h0000;
    end

    // ---------------------------------------------------------------
    // Format detector
    // ---------------------------------------------------------------
    // Line length from EAV spacing, frame from V rising in field one.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pix_cnt_reg <= 16'h0000;
            ppl_reg <= 16'h0000;
            line_cnt_reg <= 16'h0000;
            lpf_reg <= 16'h0000;
            prev_v_reg <= 1'b0;
            il_seen_reg <= 1'b0;
            interlaced_reg <= 1'b0;
        end
        else if (eav && !comp_mode)
        begin
            pix_cnt_reg <= 16'h0000;
            ppl_reg <= pix_cnt_reg + 16'h0001;
            prev_v_reg <= trs_hit.code[`SRM_XYZ_V];
            if (hd_fs)
            begin
                line_cnt_reg <= 16'h0001;
                lpf_reg <= line_cnt_reg;
                interlaced_reg <= il_seen_reg;
                il_seen_reg <= 1'b0;
            end
            else
            begin
                line_cnt_reg <= line_cnt_reg + 16'h0001;
                il_seen_reg <= il_seen_reg || trs_hit.code[`SRM_XYZ_F];
            end
        end
        else if (rx.valid)
            pix_cnt_reg <= pix_cnt_reg + 16'h0001;
    end

    // A frame longer than the reference by more than half the 1/1001 step is fractional.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fcyc_cnt_reg <= 32'h0000_0000;
            fcyc_reg <= 32'h0000_0000;
            frac_reg <= 1'b0;
        end
        else if (frame_start)
        begin
            fcyc_cnt_reg <= 32'h0000_0001;
            fcyc_reg <= fcyc_cnt_reg;
            frac_reg <= fref_reg != 32'h0 && fcyc_cnt_reg > fref_reg + (fref_reg >> `SRM_FRAC_SHIFT);
        end
        else
            fcyc_cnt_reg <= fcyc_cnt_reg + 32'h0000_0001;
    end

    // ---------------------------------------------------------------
    // Ancillary capture
    // ---------------------------------------------------------------
    // Shadows fill during the frame and are copied out whole at frame start.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 16; i++)
            begin
                hd_shadow[i] <= 10'h000;
                hd_anc[i] <= 10'h000;
                cp_shadow[i] <= 10'h000;
                cp_anc[i] <= 10'h000;
            end
            cp_arm_reg <= 1'b0;
            cp_left_reg <= 5'h00;
        end
        else
        begin
            if (rx.valid && !comp_mode && line_cnt_reg == 16'(anc_line_reg)
                && pix_cnt_reg >= 16'(anc_hpos_reg) && pix_cnt_reg < 16'(anc_hpos_reg) + 16'(`SRM_ANC_WORDS))
                hd_shadow[4'(pix_cnt_reg - 16'(anc_hpos_reg))] <= rx.word;
            if (hd_fs)
                hd_anc <= hd_shadow;
            if (cp_hit.hit && comp_mode)
                cp_arm_reg <= cp_hit.code[`SRM_CP_ANC];
            if (crc_clr && comp_mode && cp_arm_reg)
                cp_left_reg <= `SRM_ANC_WORDS;
            else if (cp_left_reg != 5'h00 && rx.valid && st_reg == S_IDLE)
            begin
                cp_shadow[4'(`SRM_ANC_WORDS - cp_left_reg)] <= rx.word;
                cp_left_reg <= cp_left_reg - 5'h01;
            end
            if (cp_fs)
                cp_anc <= cp_shadow;
        end
    end

    // ---------------------------------------------------------------
    // APB slave
    // ---------------------------------------------------------------
    // One wait state: data and pready come from flops a cycle after the access phase.
    assign access = psel && penable && !pready;
    assign wr_do = psel && penable && pready && pwrite;

    // Read mux; anything unlisted or misaligned answers with an error.
    always_comb
    begin
        rd_ok = paddr[1:0] == 2'h0;
        rd_data = 32'h0000_0000;
        if (paddr[7:6] == `SRM_HD_ANC_BLK)
            rd_data = {22'h0, hd_anc[paddr[5:2]]};
        else if (paddr[7:6] == `SRM_CP_ANC_BLK)
            rd_data = {22'h0, cp_anc[paddr[5:2]]};
        else
            unique case (paddr)
                `SRM_ANC_POS: rd_data = {4'h0, anc_hpos_reg, 5'h00, anc_line_reg};
                `SRM_STATUS: rd_data = {24'h0, frac_reg, interlaced_reg, cp_lock_reg, hd_lock_reg,
                    comp_mode, ext_eq_detect_b, ext_eq_detect_a, signal_present};
                `SRM_FMT: rd_data = {lpf_reg, ppl_reg};
                `SRM_CRC_ERR: rd_data = {16'h0, crc_err_reg};
                `SRM_FRAME_REF: rd_data = fref_reg;
                `SRM_FRAME_CYC: rd_data = fcyc_reg;
                default: rd_ok = 1'b0;
            endcase
    end

    // Answer flops.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= access;
            pslverr <= access && !rd_ok;
            prdata <= (access && !pwrite && rd_ok) ? rd_data : 32'h0000_0000;
        end
    end

    // Writable registers take effect at the edge that completes the transfer.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            anc_line_reg <= `SRM_ANC_LINE_RST;
            anc_hpos_reg <= `SRM_ANC_HPOS_RST;
            fref_reg <= `SRM_FRAME_REF_RST;
        end
        else if (wr_do && paddr == `SRM_ANC_POS)
        begin
            anc_line_reg <= pwdata[10:0];
            anc_hpos_reg <= pwdata[27:16];
        end
        else if (wr_do && paddr == `SRM_FRAME_REF)
            fref_reg <= pwdata;
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_sp_loss: assert property (!cdr_lock |=> !signal_present)
        else $error("presence stayed high without lock");
    a_sp_rise: assert property (cdr_lock && decoder_active && !stuck_reg |=> signal_present)
        else $error("presence did not rise");
    a_crc_hold: assert property (!crc_bad_reg && !(wr_do && paddr == `SRM_CRC_ERR) |=> $stable(crc_err_reg))
        else $error("error count moved without mismatch");
    a_crc_incr: assert property (crc_bad_reg && !wr_do && crc_err_reg != `SRM_ERR_MAX
        |=> crc_err_reg == $past(crc_err_reg) + 16'h0001)
        else $error("error count did not step");
    a_crc_sat: assert property (crc_err_reg == `SRM_ERR_MAX && !wr_do |=> crc_err_reg == `SRM_ERR_MAX)
        else $error("error count wrapped");
    a_crc_seq: assert property (st_reg == S_CRC0 && rx.valid |=> st_reg == S_CRC1)
        else $error("checksum capture skipped a word");
    a_fmt_ppl: assert property (eav && !comp_mode |=> ppl_reg == $past(pix_cnt_reg) + 16'h0001)
        else $error("line length wrong");
    a_anc_copy: assert property (hd_fs |=> hd_anc[0] == $past(hd_shadow[0]))
        else $error("ancillary set not refreshed");
    a_rst_clear: assert property (@(posedge pclk) $rose(presetn)
        |-> crc_err_reg == 16'h0 && !signal_present && ppl_reg == 16'h0)
        else $error("reset left state set");
endmodule
`default_nettype wire

// File: verif/srm_rx_src.sv
// Far-end model of the receive path: word stream, CDR lock and decoder state.
// Assumes pclk from the bench; every change lands just after a rising edge.
`default_nettype none
module srm_rx_src import srm_pkg::*; (
    // Clock.
    input wire logic pclk,
    // Receive path toward the monitor.
    output srm_rx_t rx,
    output logic cdr_lock,
    output logic decoder_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic idle = 1'b1; // High between bursts.
    initial
    begin
        rx = '0;
        cdr_lock = 1'b0;
        decoder_active = 1'b0;
    end
    // Between bursts the word toggles so a stale value never looks like data.
    always @(posedge pclk)
        if (idle)
            rx <= '{1'b0, ~rx.word};
    // Send one valid word.
    task automatic send(input logic [9:0] w);
        idle = 1'b0;
        @(posedge pclk);
        rx <= '{1'b1, w};
    endtask
    // End a burst; idle toggling resumes an edge later so rx is never driven twice in one step.
    task automatic stop();
        @(posedge pclk);
        rx <= '{1'b0, ~rx.word};
        @(negedge pclk);
        idle = 1'b1;
    endtask
    // Set lock and decoder levels.
    task automatic link(input logic l, input logic a);
        @(posedge pclk);
        cdr_lock <= l;
        decoder_active <= a;
    endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench of the receive status monitor.
// Assumes the monitor answers APB after one wait state and a 4 ns pclk.
`include "srm_regs.svh"
`default_nettype none
module tb import srm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic cdr_lock, decoder_active, ext_a, ext_b, signal_present;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    srm_rx_t rx;
    int fails, samples_checked;
    localparam logic [29:0] HD_PRE = {`SRM_TRS_P0, `SRM_TRS_P1, `SRM_TRS_P2}; // Standard sync preamble.
    localparam logic [29:0] CP_PRE = {`SRM_CP_P0, `SRM_CP_P1, `SRM_CP_P2}; // Compressed sync preamble.
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    srm_rx_src u_srm_rx_src (.pclk(pclk), .rx(rx), .cdr_lock(cdr_lock), .decoder_active(decoder_active));
    // Short lock-loss count keeps the run brief.
    srm_rx_status_monitor #(.LOCK_LOSS_CYC(200)) u_srm_rx_status_monitor (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx(rx), .cdr_lock(cdr_lock), .decoder_active(decoder_active),
        .ext_eq_detect_a(ext_a), .ext_eq_detect_b(ext_b), .signal_present(signal_present));
    task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // One APB transfer; the wait for pready is bounded.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
        begin
            fails++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One HD line end whose checksum words cannot match the running value.
    task automatic bad_line();
        logic [9:0] w[8] = '{10'h3ff, 10'h000, 10'h000, 10'h274, 10'h200, 10'h200, 10'h1ff, 10'h1ff};
        foreach (w[i])
            u_srm_rx_src.send(w[i]);
        u_srm_rx_src.stop();
    endtask
    // One sync group: three preamble words, a code word, then n words counting up from base.
    task automatic group(input logic [29:0] pre, input logic [9:0] code, input logic [9:0] base, input int n);
        u_srm_rx_src.send(pre[29:20]);
        u_srm_rx_src.send(pre[19:10]);
        u_srm_rx_src.send(pre[9:0]);
        u_srm_rx_src.send(code);
        for (int k = 0; k < n; k++)
            u_srm_rx_src.send(base + 10'(k));
    endtask
    // Ten 32-word lines per frame; line 8 of the first frame carries the ancillary words.
    task automatic hd_frame_test();
        apb(1'b1, `SRM_FRAME_REF, 32'h0000_013f);
        for (int i = 0; i < 11; i++)
            group(HD_PRE, i % 10 == 0 ? 10'h2c4 : 10'h274, 10'h100, 28);
        u_srm_rx_src.stop();
        apb(1'b0, `SRM_FMT, 32'h0);
        check("fmt", rd, 32'h000a_0020);
        apb(1'b0, `SRM_FRAME_CYC, 32'h0);
        check("frame_cyc", rd, 32'h0000_0140);
        apb(1'b0, `SRM_STATUS, 32'h0);
        check("scan_rate", rd & 32'h0000_00f8, 32'h0000_0090);
        for (int j = 0; j < 16; j++)
        begin
            apb(1'b0, 8'h40 + 8'(4 * j), 32'h0);
            check("hd_anc", rd, 32'h0000_0104 + 32'(j));
        end
        $display("hd frame test done");
    endtask
    // Compressed packets: one to lock, one announcing ancillary words, one frame start.
    task automatic cp_test();
        repeat (200) @(posedge pclk);
        group(CP_PRE, 10'h000, 10'h100, 2);
        group(CP_PRE, 10'h100, 10'h13e, 18);
        group(CP_PRE, 10'h200, 10'h100, 2);
        u_srm_rx_src.stop();
        apb(1'b0, `SRM_STATUS, 32'h0);
        check("cp_mode", rd & 32'h0000_0038, 32'h0000_0028);
        for (int j = 0; j < 16; j++)
        begin
            apb(1'b0, 8'h80 + 8'(4 * j), 32'h0);
            check("cp_anc", rd, 32'h0000_0140 + 32'(j));
        end
        apb(1'b0, 8'h40, 32'h0);
        check("hd_anc", rd, 32'h0000_0104);
        $display("compressed test done");
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ext_a, ext_b} = {1'b0, 43'h0, 1'b1, 1'b0};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check("present", signal_present, 32'h0);
        apb(1'b0, `SRM_CRC_ERR, 32'h0);
        check("crc_err", rd, 32'h0);
        apb(1'b0, `SRM_FMT, 32'h0);
        check("fmt", rd, 32'h0);
        $display("reset test done");
        u_srm_rx_src.link(1'b1, 1'b1);
        repeat (4) @(posedge pclk);
        check("present", signal_present, 32'h1);
        apb(1'b0, `SRM_STATUS, 32'h0);
        check("status", rd[2:0], 3'h3);
        u_srm_rx_src.link(1'b0, 1'b1);
        repeat (3) @(posedge pclk);
        check("present", signal_present, 32'h0);
        $display("presence test done");
        bad_line();
        bad_line();
        repeat (4) @(posedge pclk);
        apb(1'b0, `SRM_CRC_ERR, 32'h0);
        check("crc_err", rd, 32'h2);
        apb(1'b0, `SRM_STATUS, 32'h0);
        check("std_lock", rd[4], 32'h1);
        apb(1'b1, `SRM_CRC_ERR, 32'h0);
        apb(1'b0, `SRM_CRC_ERR, 32'h0);
        check("crc_err", rd, 32'h0);
        $display("checksum test done");
        apb(1'b0, `SRM_ANC_POS, 32'h0);
        check("anc_pos", rd, 32'h8);
        apb(1'b1, `SRM_ANC_POS, 32'h0004_0008);
        apb(1'b0, `SRM_ANC_POS, 32'h0);
        check("anc_pos", rd, 32'h0004_0008);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped", err, 32'h1);
        apb(1'b0, 8'h01, 32'h0);
        check("misaligned", err, 32'h1);
        $display("register test done");
        hd_frame_test();
        cp_test();
        give_verdict();
    end
endmodule
`default_nettype wire
